// ===== design/gdmc_defines.svh
`ifndef GDMC_DEFINES_SVH
`define GDMC_DEFINES_SVH

`define GDMC_NPINS 8
`define GDMC_AW 8
`define GDMC_DW 8

`define GDMC_A_DM0 8'h00
`define GDMC_A_DM1 8'h01
`define GDMC_A_DM2 8'h02
`define GDMC_A_OUT 8'h03
`define GDMC_A_PST 8'h04
`define GDMC_A_BYP 8'h05
`define GDMC_A_IBD 8'h06
`define GDMC_A_SLW 8'h07
`define GDMC_A_REG 8'h08
`define GDMC_A_IRR 8'h09
`define GDMC_A_IRF 8'h0A
`define GDMC_A_IST 8'h0B
`define GDMC_A_USB 8'h0C
`define GDMC_A_PIN_BASE 8'h10

`define GDMC_USB_MASK 8'hC0
`define GDMC_RST_DM 24'h000000
`define GDMC_RST_OUT 8'h00

`define GDMC_PF_DM_LSB 0
`define GDMC_PF_OUT 3
`define GDMC_PF_BYP 4
`define GDMC_PF_SLW 5
`define GDMC_PF_IRR 6
`define GDMC_PF_IRF 7

`define GDMC_DM_HIZ_ANA 3'h0
`define GDMC_DM_HIZ_DIG 3'h1
`define GDMC_DM_RES_UP 3'h2
`define GDMC_DM_RES_DN 3'h3
`define GDMC_DM_OD_LO 3'h4
`define GDMC_DM_OD_HI 3'h5
`define GDMC_DM_STRONG 3'h6
`define GDMC_DM_RES_BOTH 3'h7

`endif

// ===== design/gdmc_pkg.sv
package gdmc_pkg;
    typedef struct packed {
        logic pull_up;
        logic pull_down;
        logic ibuf_en;
        logic slew_fast;
    } gdmc_pin_aux_t;

    typedef struct packed {
        logic drv_hi;
        logic drv_lo;
        logic pull_up;
        logic pull_down;
        logic ibuf_en;
    } gdmc_drive_t;
endpackage

// ===== design/gdmc_port.sv
`timescale 1ns/10ps
`include "gdmc_defines.svh"
// What this block does
// - Every pin holds its own three-bit drive-mode field.
// - Driven level comes from output value, or fabric signal under bypass.
// - Mode 0 is reset default: driver and input buffer both off.
// - Mode 1 floats output for both data values, input buffer on.
// - Mode 2 resistive high/strong low; mode 3 strong high/resistive low.
// - Mode 4 floats on data 1, strong low on data 0.
// - Mode 5 strong high on data 1, floats on data 0.
// - Mode 6 strong high and strong low.
// - Mode 7 resistive high and resistive low.
// - Regulated special pins lose the resistive parts of modes 2, 3, 7.
// - USB-capable pins have only drive select and pull-up enable.
// - USB pin: 0 strong low; 1 strong, resistive or floating high.
// - In USB operation the USB pin controls have no effect.
// - Port-wide mode writes leave USB pin mode bits untouched.
// - Pin interrupts on rising, falling or both edges; no level mode.
// - One interrupt request line for the whole port.
// - Pin-state read path is separate from output value storage.
// - Port words and per-pin words reach the same storage.
// - Reset state of the port is user programmable.
// - An enabled edge sets its status bit and raises the port request.
// - Per-pin slew select, applied only in strong and open-drain modes.
module gdmc_port
    import gdmc_pkg::*;
#(
    parameter logic [23:0] RST_DM = `GDMC_RST_DM,
    parameter logic [7:0] RST_OUT = `GDMC_RST_OUT
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] fabric_out,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output gdmc_pin_aux_t [7:0] pin_aux,
    output logic usb_mode,
    output logic port_irq
);

    logic [2:0] pin_mode_bits_ff [7:0];
    logic [7:0] port_output_value_ff;
    logic [7:0] bypass_ff, ibuf_dis_ff, pin_slew_select_ff, regulated_ff;
    logic [7:0] irq_rise_ff, irq_fall_ff, irq_status_ff;
    logic usb_mode_ff;
    logic [7:0] sync1_ff, sync2_ff, prev_ff;
    logic [7:0] reg_rdata_ff;
    logic [7:0] port_pin_state, drv_data, ibuf_on, edge_hit, nxt_irq_status;
    logic pin_wr;
    logic [2:0] pin_idx;

    function automatic gdmc_drive_t gdmc_decode(input logic [2:0] dm, input logic d,
                                                input logic reg_out);
        gdmc_drive_t r;
        r = '0;
        r.ibuf_en = (dm != `GDMC_DM_HIZ_ANA);
        case (dm)
            `GDMC_DM_HIZ_ANA, `GDMC_DM_HIZ_DIG: r.drv_hi = 1'b0;
            `GDMC_DM_RES_UP: begin
                r.pull_up = d;
                r.drv_lo = !d;
            end
            `GDMC_DM_RES_DN: begin
                r.drv_hi = d;
                r.pull_down = !d;
            end
            `GDMC_DM_OD_LO: r.drv_lo = !d;
            `GDMC_DM_OD_HI: r.drv_hi = d;
            `GDMC_DM_STRONG: begin
                r.drv_hi = d;
                r.drv_lo = !d;
            end
            `GDMC_DM_RES_BOTH: begin
                r.pull_up = d;
                r.pull_down = !d;
            end
            default: r = '0;
        endcase
        // Regulated level cannot source through the resistor
        if (reg_out) begin
            r.pull_up = 1'b0;
            r.pull_down = 1'b0;
        end
        return r;
    endfunction

    function automatic logic gdmc_strong_mode(input logic [2:0] dm);
        return dm[2] && (dm != `GDMC_DM_RES_BOTH);
    endfunction

    // Pins 6 and 7 are the USB-capable pair
    function automatic logic gdmc_usb_pin(input logic [2:0] idx);
        logic [7:0] mask;
        mask = `GDMC_USB_MASK;
        return mask[idx];
    endfunction

    assign pin_wr = reg_wr && ({reg_addr[7:3], 3'h0} == `GDMC_A_PIN_BASE);
    assign pin_idx = reg_addr[2:0];

    ////////////////////////////////////////////////////////////////////////////
    // Configuration storage, port form and pin form share it

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < 8; i++) begin
            if (!resetn) begin
                pin_mode_bits_ff[i] <= {RST_DM[16 + i], RST_DM[8 + i], RST_DM[i]};
            end else if (pin_wr && pin_idx == i[2:0]) begin
                pin_mode_bits_ff[i] <= reg_wdata[`GDMC_PF_DM_LSB +: 3];
            end else if (reg_wr && !gdmc_usb_pin(i[2:0])) begin
                if (reg_addr == `GDMC_A_DM0) pin_mode_bits_ff[i][0] <= reg_wdata[i];
                if (reg_addr == `GDMC_A_DM1) pin_mode_bits_ff[i][1] <= reg_wdata[i];
                if (reg_addr == `GDMC_A_DM2) pin_mode_bits_ff[i][2] <= reg_wdata[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            port_output_value_ff <= RST_OUT;
            bypass_ff <= 8'h00;
            pin_slew_select_ff <= 8'h00;
            irq_rise_ff <= 8'h00;
            irq_fall_ff <= 8'h00;
        end else if (pin_wr) begin
            port_output_value_ff[pin_idx] <= reg_wdata[`GDMC_PF_OUT];
            bypass_ff[pin_idx] <= reg_wdata[`GDMC_PF_BYP];
            pin_slew_select_ff[pin_idx] <= reg_wdata[`GDMC_PF_SLW];
            irq_rise_ff[pin_idx] <= reg_wdata[`GDMC_PF_IRR];
            irq_fall_ff[pin_idx] <= reg_wdata[`GDMC_PF_IRF];
        end else if (reg_wr) begin
            case (reg_addr)
                `GDMC_A_OUT: port_output_value_ff <= reg_wdata;
                `GDMC_A_BYP: bypass_ff <= reg_wdata;
                `GDMC_A_SLW: pin_slew_select_ff <= reg_wdata;
                `GDMC_A_IRR: irq_rise_ff <= reg_wdata;
                `GDMC_A_IRF: irq_fall_ff <= reg_wdata;
                default: bypass_ff <= bypass_ff;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ibuf_dis_ff <= 8'h00;
            regulated_ff <= 8'h00;
            usb_mode_ff <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `GDMC_A_IBD) ibuf_dis_ff <= reg_wdata;
            // USB pins have no regulated option
            if (reg_addr == `GDMC_A_REG) regulated_ff <= reg_wdata & ~`GDMC_USB_MASK;
            if (reg_addr == `GDMC_A_USB) usb_mode_ff <= reg_wdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive

    assign drv_data = (bypass_ff & fabric_out) | (~bypass_ff & port_output_value_ff);

    always_comb begin
        gdmc_drive_t d;
        logic usb_pin;
        d = '0;
        usb_pin = 1'b0;
        for (int i = 0; i < 8; i++) begin
            usb_pin = gdmc_usb_pin(i[2:0]);
            d = gdmc_decode(pin_mode_bits_ff[i], drv_data[i], regulated_ff[i]);
            if (usb_pin) begin
                // Bit 0 is drive select, bit 1 pull-up enable
                d = '0;
                d.ibuf_en = 1'b1;
                d.drv_lo = !drv_data[i];
                d.drv_hi = drv_data[i] && pin_mode_bits_ff[i][0];
                d.pull_up = drv_data[i] && !pin_mode_bits_ff[i][0] && pin_mode_bits_ff[i][1];
                if (usb_mode_ff) d = '0;
            end
            ibuf_on[i] = d.ibuf_en && !ibuf_dis_ff[i];
            pin_out[i] = d.drv_hi;
            pin_oe_n[i] = !(d.drv_hi || d.drv_lo);
            pin_aux[i].pull_up = d.pull_up;
            pin_aux[i].pull_down = d.pull_down;
            pin_aux[i].ibuf_en = ibuf_on[i];
            // Resistive modes ignore slew
            pin_aux[i].slew_fast = pin_slew_select_ff[i] && !usb_pin
                && gdmc_strong_mode(pin_mode_bits_ff[i]);
        end
    end

    assign usb_mode = usb_mode_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Input sampling and edge interrupts

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
            prev_ff <= 8'h00;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            prev_ff <= port_pin_state;
        end
    end

    // Disabled buffer reads low and so cannot make edges
    assign port_pin_state = sync2_ff & ibuf_on;
    assign edge_hit = (port_pin_state & ~prev_ff & irq_rise_ff)
        | (~port_pin_state & prev_ff & irq_fall_ff);

    always_comb begin
        nxt_irq_status = irq_status_ff;
        if (reg_wr && reg_addr == `GDMC_A_IST) nxt_irq_status = irq_status_ff & ~reg_wdata;
        nxt_irq_status = nxt_irq_status | edge_hit;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) irq_status_ff <= 8'h00;
        else irq_status_ff <= nxt_irq_status;
    end

    assign port_irq = |irq_status_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_ff <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                if (reg_addr == `GDMC_A_DM0) reg_rdata_ff[i] <= pin_mode_bits_ff[i][0];
                if (reg_addr == `GDMC_A_DM1) reg_rdata_ff[i] <= pin_mode_bits_ff[i][1];
                if (reg_addr == `GDMC_A_DM2) reg_rdata_ff[i] <= pin_mode_bits_ff[i][2];
            end
            case (reg_addr)
                `GDMC_A_OUT: reg_rdata_ff <= port_output_value_ff;
                `GDMC_A_PST: reg_rdata_ff <= port_pin_state;
                `GDMC_A_BYP: reg_rdata_ff <= bypass_ff;
                `GDMC_A_IBD: reg_rdata_ff <= ibuf_dis_ff;
                `GDMC_A_SLW: reg_rdata_ff <= pin_slew_select_ff;
                `GDMC_A_REG: reg_rdata_ff <= regulated_ff;
                `GDMC_A_IRR: reg_rdata_ff <= irq_rise_ff;
                `GDMC_A_IRF: reg_rdata_ff <= irq_fall_ff;
                `GDMC_A_IST: reg_rdata_ff <= irq_status_ff;
                `GDMC_A_USB: reg_rdata_ff <= {7'h00, usb_mode_ff};
                default: begin
                    if ({reg_addr[7:3], 3'h0} == `GDMC_A_PIN_BASE) begin
                        reg_rdata_ff <= {irq_fall_ff[pin_idx], irq_rise_ff[pin_idx],
                            pin_slew_select_ff[pin_idx], bypass_ff[pin_idx],
                            port_output_value_ff[pin_idx], pin_mode_bits_ff[pin_idx]};
                    end
                end
            endcase
        end
    end

    assign reg_rdata = reg_rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_mode0_off;
        @(posedge ref_clk) disable iff (!resetn)
        (pin_mode_bits_ff[0] == 3'h0) |-> (pin_oe_n[0] && !pin_aux[0].ibuf_en);
    endproperty
    a_mode0_off: assert property (p_mode0_off) else $error("mode 0 not off");

    property p_strong;
        @(posedge ref_clk) disable iff (!resetn)
        (pin_mode_bits_ff[0] == 3'h6) |-> (!pin_oe_n[0] && pin_out[0] == drv_data[0]);
    endproperty
    a_strong: assert property (p_strong) else $error("strong mode wrong");

    property p_od_lo;
        @(posedge ref_clk) disable iff (!resetn)
        (pin_mode_bits_ff[0] == 3'h4 && drv_data[0]) |-> pin_oe_n[0];
    endproperty
    a_od_lo: assert property (p_od_lo) else $error("open drain low drove");

    property p_out_write;
        @(posedge ref_clk) disable iff (!resetn)
        (reg_wr && reg_addr == `GDMC_A_OUT) |=> (port_output_value_ff == $past(reg_wdata));
    endproperty
    a_out_write: assert property (p_out_write) else $error("output write lost");

    property p_usb_keep;
        @(posedge ref_clk) disable iff (!resetn)
        (reg_wr && reg_addr == `GDMC_A_DM0) |=> $stable(pin_mode_bits_ff[7]);
    endproperty
    a_usb_keep: assert property (p_usb_keep) else $error("port write hit usb pin");

    property p_rise_irq;
        @(posedge ref_clk) disable iff (!resetn)
        (irq_rise_ff[1] && ibuf_on[1] && $rose(sync2_ff[1])) |=> (irq_status_ff[1] && port_irq);
    endproperty
    a_rise_irq: assert property (p_rise_irq) else $error("rising edge missed");

    property p_no_edge;
        @(posedge ref_clk) disable iff (!resetn)
        (irq_rise_ff == 8'h00 && irq_fall_ff == 8'h00 && !(reg_wr && reg_addr == `GDMC_A_IST))
        |=> (irq_status_ff == $past(irq_status_ff));
    endproperty
    a_no_edge: assert property (p_no_edge) else $error("status set with edges off");

    property p_usb_mode;
        @(posedge ref_clk) disable iff (!resetn)
        usb_mode_ff |-> (pin_oe_n[7:6] == 2'b11 && !pin_aux[6].pull_up && !pin_aux[7].pull_up);
    endproperty
    a_usb_mode: assert property (p_usb_mode) else $error("usb pin driven in usb mode");

    property p_res_slew;
        @(posedge ref_clk) disable iff (!resetn)
        (pin_mode_bits_ff[0] == 3'h7) |-> !pin_aux[0].slew_fast;
    endproperty
    a_res_slew: assert property (p_res_slew) else $error("slew on resistive mode");

    property p_regulated;
        @(posedge ref_clk) disable iff (!resetn)
        regulated_ff[0] |-> !(pin_aux[0].pull_up || pin_aux[0].pull_down);
    endproperty
    a_regulated: assert property (p_regulated) else $error("resistive on regulated pin");

    property p_hiz_dig;
        @(posedge ref_clk) disable iff (!resetn)
        (pin_mode_bits_ff[0] == `GDMC_DM_HIZ_DIG) |-> (pin_oe_n[0] && !pin_aux[0].pull_up
            && !pin_aux[0].pull_down && pin_aux[0].ibuf_en == !ibuf_dis_ff[0]);
    endproperty
    a_hiz_dig: assert property (p_hiz_dig) else $error("mode 1 not a floating input");

    property p_res_up;
        @(posedge ref_clk) disable iff (!resetn)
        (pin_mode_bits_ff[0] == `GDMC_DM_RES_UP && !regulated_ff[0]) |-> (drv_data[0]
            ? (pin_oe_n[0] && pin_aux[0].pull_up) : (!pin_oe_n[0] && !pin_out[0]));
    endproperty
    a_res_up: assert property (p_res_up) else $error("mode 2 drive wrong");

    property p_od_hi;
        @(posedge ref_clk) disable iff (!resetn)
        (pin_mode_bits_ff[0] == `GDMC_DM_OD_HI)
            |-> (drv_data[0] ? (!pin_oe_n[0] && pin_out[0]) : pin_oe_n[0]);
    endproperty
    a_od_hi: assert property (p_od_hi) else $error("open drain high wrong");

    property p_res_both;
        @(posedge ref_clk) disable iff (!resetn)
        (pin_mode_bits_ff[0] == `GDMC_DM_RES_BOTH && !regulated_ff[0]) |-> (pin_oe_n[0]
            && pin_aux[0].pull_up == drv_data[0] && pin_aux[0].pull_down == !drv_data[0]);
    endproperty
    a_res_both: assert property (p_res_both) else $error("mode 7 pulls wrong");

    property p_usb_drive;
        @(posedge ref_clk) disable iff (!resetn)
        (!usb_mode_ff && !drv_data[7]) |-> (!pin_oe_n[7] && !pin_out[7]);
    endproperty
    a_usb_drive: assert property (p_usb_drive) else $error("usb pin not strong low");

    property p_bypass;
        @(posedge ref_clk) disable iff (!resetn)
        (pin_mode_bits_ff[2] == `GDMC_DM_STRONG && bypass_ff[2])
            |-> (!pin_oe_n[2] && pin_out[2] == fabric_out[2]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass level wrong");

    property p_pin_form;
        @(posedge ref_clk) disable iff (!resetn)
        (pin_wr && pin_idx == 3'h0) |=> (pin_mode_bits_ff[0] == $past(reg_wdata[2:0])
            && port_output_value_ff[0] == $past(reg_wdata[3]));
    endproperty
    a_pin_form: assert property (p_pin_form) else $error("pin form write lost");

endmodule

// ===== sim/gdmc_board.sv
`timescale 1ns/10ps
// Board around the port: the port's own driver, else an external driver per pin, else pulls, else noise
module gdmc_board
    import gdmc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire gdmc_pin_aux_t [7:0] pin_aux,
    input wire logic [7:0] ext_level,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    logic [7:0] noise_ff = 8'h55;

    // Floating pins wander so an unknown never settles into a fixed level
    always @(posedge ref_clk) begin
        noise_ff <= ~noise_ff;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_level[i];
            end else if (pin_aux[i].pull_up) begin
                pin_in[i] = 1'b1;
            end else if (pin_aux[i].pull_down) begin
                pin_in[i] = 1'b0;
            end else begin
                pin_in[i] = noise_ff[i];
            end
        end
    end
endmodule

// ===== sim/gdmc_port_tb.sv
`timescale 1ns/10ps
`include "gdmc_defines.svh"
module gdmc_port_tb
    import gdmc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] fabric_out = 8'h00;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
    gdmc_pin_aux_t [7:0] pin_aux;
    logic usb_mode;
    logic port_irq;
    logic [7:0] ext_level = 8'h00;
    logic [7:0] ext_en = 8'h02;
    int failures = 0;
    int checks = 0;

    always #50 ref_clk = ~ref_clk;

    gdmc_port gdmc_port_inst (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fabric_out(fabric_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_aux(pin_aux), .usb_mode(usb_mode), .port_irq(port_irq));

    gdmc_board gdmc_board_inst (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_aux(pin_aux), .ext_level(ext_level), .ext_en(ext_en), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Ends just after the strobe edge, so effects are visible one step later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, reg_rdata, exp);
    endtask

    // {oe_n, out, pull_up, pull_down, ibuf_en, slew_fast} of one pin
    function automatic logic [5:0] pin_view(input int i);
        return {pin_oe_n[i], pin_out[i], pin_aux[i].pull_up, pin_aux[i].pull_down,
                pin_aux[i].ibuf_en, pin_aux[i].slew_fast};
    endfunction

    function automatic logic [5:0] mode_exp(input logic [2:0] m, input logic d);
        case (m)
            3'h0: return 6'h20;
            3'h1: return 6'h22;
            3'h2: return d ? 6'h2A : 6'h02;
            3'h3: return d ? 6'h12 : 6'h26;
            3'h4: return d ? 6'h23 : 6'h03;
            3'h5: return d ? 6'h13 : 6'h23;
            3'h6: return d ? 6'h13 : 6'h03;
            default: return d ? 6'h2A : 6'h26;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic sc_reset();
        chk("oe_n", {2'h0, pin_oe_n[5:0]}, 8'h3F);
        chk("out", {2'h0, pin_out[5:0]}, 8'h00);
        chk("irq", {7'h00, port_irq}, 8'h00);
        rd_chk("dm0", `GDMC_A_DM0, 8'h00);
    endtask

    // Slew requested in every mode of pin 0; only modes 4 to 6 may honour it
    task automatic sc_modes();
        for (int k = 0; k < 16; k++) begin
            wr(`GDMC_A_PIN_BASE, {3'h1, 1'b0, k[0], k[3:1]});
            chk("mode", {2'h0, pin_view(0)}, {2'h0, mode_exp(k[3:1], k[0])});
            rd_chk("pinform", `GDMC_A_PIN_BASE, {3'h1, 1'b0, k[0], k[3:1]});
            rd_chk("dm1", `GDMC_A_DM1, {7'h00, k[2]});
        end
        rd_chk("slw", `GDMC_A_SLW, 8'h01);
        wr(`GDMC_A_BYP, 8'h01);
        rd_chk("byp form", `GDMC_A_PIN_BASE, 8'h3F);
        wr(`GDMC_A_BYP, 8'h00);
        wr(`GDMC_A_IBD, 8'h01);
        chk("ibuf off", {7'h00, pin_aux[0].ibuf_en}, 8'h00);
        rd_chk("ibd", `GDMC_A_IBD, 8'h01);
        wr(`GDMC_A_IBD, 8'h00);
    endtask

    task automatic sc_bypass();
        wr(`GDMC_A_PIN_BASE + 8'h02, 8'h1E);
        @(posedge ref_clk);
        fabric_out <= 8'h04;
        #1;
        chk("byp hi", {7'h00, pin_out[2]}, 8'h01);
        @(posedge ref_clk);
        fabric_out <= 8'h00;
        #1;
        chk("byp lo", {7'h00, pin_out[2] | pin_oe_n[2]}, 8'h00);
        wr(`GDMC_A_PIN_BASE + 8'h02, 8'h00);
    endtask

    task automatic sc_regulated();
        wr(`GDMC_A_REG, 8'hFF);
        rd_chk("reg", `GDMC_A_REG, 8'h3F);
        wr(`GDMC_A_PIN_BASE, 8'h0A);
        chk("reg m2", {2'h0, pin_view(0)}, 8'h22);
        wr(`GDMC_A_PIN_BASE, 8'h07);
        chk("reg m7", {2'h0, pin_view(0)}, 8'h22);
        wr(`GDMC_A_REG, 8'h00);
        wr(`GDMC_A_PIN_BASE, 8'h00);
    endtask

    task automatic sc_usb();
        logic [3:0] cfg [5] = '{4'h9, 4'hA, 4'h8, 4'h3, 4'h2};
        logic [2:0] exp [5] = '{3'h2, 3'h5, 3'h4, 3'h0, 3'h0};
        wr(`GDMC_A_DM0, 8'hFF);
        rd_chk("dm0 usb", `GDMC_A_DM0, 8'h3F);
        wr(`GDMC_A_DM0, 8'h00);
        for (int k = 0; k < 5; k++) begin
            wr(`GDMC_A_PIN_BASE + 8'h07, {4'h0, cfg[k]});
            chk("usb pin", {5'h00, pin_oe_n[7], pin_out[7], pin_aux[7].pull_up}, {5'h00, exp[k]});
        end
        wr(`GDMC_A_PIN_BASE + 8'h07, 8'h09);
        wr(`GDMC_A_USB, 8'h01);
        chk("usb mode", {5'h00, pin_oe_n[7], pin_out[7], pin_aux[7].pull_up}, 8'h04);
        chk("usb flag", {7'h00, usb_mode}, 8'h01);
        wr(`GDMC_A_USB, 8'h00);
        wr(`GDMC_A_PIN_BASE + 8'h07, 8'h00);
    endtask

    // Edge reaches the request three cycles after the pin moves
    task automatic irq_case(input logic [7:0] cfg, input logic lvl, input logic exp);
        wr(`GDMC_A_PIN_BASE + 8'h01, cfg);
        @(posedge ref_clk);
        ext_level[1] <= lvl;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("irq", {7'h00, port_irq}, {7'h00, exp});
        rd_chk("status", `GDMC_A_IST, {6'h00, exp, 1'b0});
        rd_chk("state", `GDMC_A_PST, {6'h00, lvl, 1'b0});
        wr(`GDMC_A_IST, 8'h02);
        chk("irq clr", {7'h00, port_irq}, 8'h00);
    endtask

    task automatic sc_irq();
        wr(`GDMC_A_PIN_BASE + 8'h01, 8'h01);
        repeat (4) @(posedge ref_clk);
        wr(`GDMC_A_IST, 8'hFF);
        irq_case(8'h41, 1'b1, 1'b1);
        irq_case(8'h41, 1'b0, 1'b0);
        irq_case(8'h81, 1'b1, 1'b0);
        irq_case(8'h81, 1'b0, 1'b1);
        irq_case(8'hC1, 1'b1, 1'b1);
        irq_case(8'hC1, 1'b0, 1'b1);
        // Pin 1 stays an input held low, so its output bit must not show up
        wr(`GDMC_A_OUT, 8'h1A);
        rd_chk("pst", `GDMC_A_PST, 8'h00);
        rd_chk("out", `GDMC_A_OUT, 8'h1A);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        #1;
        sc_reset();
        sc_modes();
        sc_bypass();
        sc_regulated();
        sc_usb();
        sc_irq();
        give_verdict();
    end
endmodule
